// file: ptpe_engine.sv
// per-circuit loopback, pattern and connectivity test engine
`timescale 1ns/1ns
`default_nettype none
`include "ptpe_regs.svh"
module ptpe_engine (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic circuit_mux,
    input wire logic [23:0] cir_bps,
    input wire logic rate_override,
    input wire logic [23:0] rate_bps,
    input wire logic timeout_en,
    input wire logic [16:0] timeout_s,
    input wire logic start_loop,
    input wire logic stop_loop,
    input wire logic start_send,
    input wire logic stop_send,
    input wire logic start_mon,
    input wire logic stop_mon,
    input wire logic start_probe,
    input wire logic abort_all,
    input wire logic dte_loop_req,
    input wire logic rx_valid,
    input wire logic rx_sof,
    input wire logic rx_eof,
    input wire logic rx_test,
    input wire logic rx_probe_reply,
    input wire logic [7:0] rx_data,
    input wire logic user_valid,
    input wire logic [7:0] user_data,
    output logic user_ready,
    output logic tx_valid,
    output logic tx_sof,
    output logic tx_eof,
    output logic tx_test,
    output logic [7:0] tx_data,
    output logic loop_active,
    output logic send_active,
    output logic mon_active,
    output logic probe_active,
    output logic dte_loop_active,
    output logic [16:0] loop_elapsed_s,
    output logic [16:0] send_elapsed_s,
    output logic [16:0] mon_elapsed_s,
    output logic in_sync,
    output logic [16:0] seq_errors,
    output logic [16:0] data_errors,
    output logic seq_overflow,
    output logic data_overflow,
    output logic [16:0] rtt_ms,
    output logic rtt_valid,
    output logic no_response,
    output logic abort_done
);
    ptpe_pkg::ptpe_state_s st, next_st;
    logic ms_tick, sec_tick, any_active, send_slot, loop_fwd;
    logic [23:0] eff_rate;
    logic [4:0] miss_cnt;
    logic [16:0] limit;

    // --------------------------------------------------------------
    // rate selection and timebase
    // --------------------------------------------------------------
    // picks the pattern rate; percentage done as a plain divide
    always_comb begin
        if (rate_override) begin
            eff_rate = rate_bps;
        end else if (cir_bps == 24'h000000) begin
            eff_rate = `PTPE_ZERO_CIR_BPS;
        end else if (circuit_mux) begin
            eff_rate = 24'((32'(cir_bps) * 32'(`PTPE_MUX_PCT)) / 32'd100);
        end else begin
            eff_rate = 24'((32'(cir_bps) * 32'(`PTPE_STD_PCT)) / 32'd100);
        end
    end
    assign ms_tick = (st.ms_div == `PTPE_MS_CYC - 24'h000001);
    assign sec_tick = ms_tick && (st.sec_div == `PTPE_SEC_LAST_MS);
    // one packet per slot: accumulate rate per ms until a packet's bits
    assign send_slot = st.rate_acc >= 32'(`PTPE_PKT_BITS) * 32'd1000;
    assign limit = timeout_s;
    assign any_active = st.loop_on | st.send_on | st.mon_on |
        (st.probe == ptpe_pkg::PTPE_PR_WAIT);
    // loopback returns peer test frames toward the peer
    assign loop_fwd = st.loop_on && rx_valid && rx_test;

    // count misses in the 25-frame window
    always_comb begin
        miss_cnt = 5'h00;
        for (int i = 0; i < 25; i++) begin
            miss_cnt = miss_cnt + 5'(st.hist[i]);
        end
    end

    // --------------------------------------------------------------
    // next-state logic
    // --------------------------------------------------------------
    // one process holds all control; trades width for a single view
    always_comb begin
        next_st = st;
        next_st.ms_div = ms_tick ? 24'h000000 : st.ms_div + 24'h000001;
        if (ms_tick) begin
            next_st.sec_div = sec_tick ? 10'h000 : st.sec_div + 10'h001;
        end
        // credit only while sending, so idle time never wraps the sum
        if (ms_tick && st.send_on) begin
            next_st.rate_acc = st.rate_acc + 32'(eff_rate);
        end
        next_st.tx_valid = 1'b0;
        next_st.tx_sof = 1'b0;
        next_st.tx_eof = 1'b0;
        next_st.abort_done = 1'b0;
        // start and stop per test
        if (start_loop && !st.loop_on) begin
            next_st.loop_on = 1'b1;
            next_st.t_loop = 17'h00000;
        end else if (stop_loop) begin
            next_st.loop_on = 1'b0;
        end
        if (start_send && !st.send_on) begin
            next_st.send_on = 1'b1;
            next_st.t_send = 17'h00000;
            next_st.tx_seq = 8'h00;
            next_st.rate_acc = 32'h00000000;
        end else if (stop_send) begin
            next_st.send_on = 1'b0;
        end
        if (start_mon && !st.mon_on) begin
            next_st.mon_on = 1'b1;
            next_st.t_mon = 17'h00000;
            next_st.hist = 25'h1ffffff;
            next_st.in_sync = 1'b0;
            next_st.rx_first = 1'b1;
            next_st.seq_err = 17'h00000;
            next_st.dat_err = 17'h00000;
            next_st.seq_ovf = 1'b0;
            next_st.dat_ovf = 1'b0;
        end else if (stop_mon) begin
            next_st.mon_on = 1'b0;
        end
        // elapsed time and optional time limit
        if (sec_tick) begin
            if (st.loop_on) next_st.t_loop = st.t_loop + 17'h00001;
            if (st.send_on) next_st.t_send = st.t_send + 17'h00001;
            if (st.mon_on) next_st.t_mon = st.t_mon + 17'h00001;
            if (timeout_en) begin
                if (st.loop_on && st.t_loop >= limit) next_st.loop_on = 1'b0;
                if (st.send_on && st.t_send >= limit) next_st.send_on = 1'b0;
                if (st.mon_on && st.t_mon >= limit) next_st.mon_on = 1'b0;
            end
        end
        // connectivity probe: mux only, self-ending
        unique case (st.probe)
            ptpe_pkg::PTPE_PR_IDLE, ptpe_pkg::PTPE_PR_DONE: begin
                if (start_probe && circuit_mux) begin
                    next_st.probe = ptpe_pkg::PTPE_PR_WAIT;
                    next_st.t_probe = 17'h00000;
                    next_st.rtt_ok = 1'b0;
                    next_st.no_resp = 1'b0;
                    next_st.tx_valid = 1'b1;
                    next_st.tx_sof = 1'b1;
                    next_st.tx_eof = 1'b1;
                    next_st.tx_data = 8'h00;
                end
            end
            ptpe_pkg::PTPE_PR_WAIT: begin
                if (ms_tick) next_st.t_probe = st.t_probe + 17'h00001;
                if (rx_valid && rx_probe_reply) begin
                    next_st.rtt = st.t_probe;
                    next_st.rtt_ok = 1'b1;
                    next_st.probe = ptpe_pkg::PTPE_PR_DONE;
                end else if (st.t_probe >= `PTPE_PROBE_LIMIT_MS) begin
                    next_st.no_resp = 1'b1;
                    next_st.probe = ptpe_pkg::PTPE_PR_DONE;
                end
            end
        endcase
        // pattern transmitter, loopback has priority on the link
        if (loop_fwd) begin
            next_st.tx_valid = 1'b1;
            next_st.tx_sof = rx_sof;
            next_st.tx_eof = rx_eof;
            next_st.tx_data = rx_data;
        end else if (st.tx_busy) begin
            // a packet under way finishes, so stop_send never cuts a frame; abort_all clears tx_busy and does
            next_st.tx_valid = 1'b1;
            next_st.tx_sof = (st.byte_idx == 8'h00);
            next_st.tx_data = (st.byte_idx == 8'h00) ? st.tx_seq :
                `PTPE_FILL_BYTE;
            next_st.byte_idx = st.byte_idx + 8'h01;
            if (st.byte_idx == `PTPE_PAYLOAD_LEN) begin
                next_st.tx_eof = 1'b1;
                next_st.tx_busy = 1'b0;
                next_st.tx_seq = st.tx_seq + 8'h01;
            end
        end else if (st.send_on && send_slot &&
                st.probe != ptpe_pkg::PTPE_PR_WAIT) begin
            // keeps the credit added by this cycle's ms tick
            next_st.rate_acc = next_st.rate_acc -
                32'(`PTPE_PKT_BITS) * 32'd1000;
            next_st.tx_busy = 1'b1;
            next_st.byte_idx = 8'h00;
        end
        // monitor: first byte is the sequence, rest must be fill
        if (st.mon_on && rx_valid && rx_test) begin
            next_st.rx_idx = rx_sof ? 8'h01 : st.rx_idx + 8'h01;
            if (rx_sof) begin
                next_st.rx_bad_pkt = 1'b0;
                next_st.rx_first = 1'b0;
                next_st.rx_seq_exp = rx_data + 8'h01;
                next_st.hist = {st.hist[23:0],
                    !st.rx_first && rx_data != st.rx_seq_exp};
                if (!st.rx_first && rx_data != st.rx_seq_exp && st.in_sync)
                    next_st.seq_err = (st.seq_err == `PTPE_CNT_MAX) ?
                        st.seq_err : st.seq_err + 17'h00001;
                if (st.seq_err == `PTPE_CNT_MAX) next_st.seq_ovf = 1'b1;
            end else if (rx_data != `PTPE_FILL_BYTE && !st.rx_bad_pkt) begin
                next_st.rx_bad_pkt = 1'b1;
                if (st.in_sync)
                    next_st.dat_err = (st.dat_err == `PTPE_CNT_MAX) ?
                        st.dat_err : st.dat_err + 17'h00001;
                if (st.dat_err == `PTPE_CNT_MAX) next_st.dat_ovf = 1'b1;
            end
            next_st.in_sync = (miss_cnt < `PTPE_LOSS_LIMIT);
        end
        // refresh reported counts once per second
        if (sec_tick) begin
            next_st.seq_rep = st.seq_err;
            next_st.dat_rep = st.dat_err;
        end
        // abort-all stops pattern and loopback tests but not dte loops
        if (abort_all) begin
            next_st.loop_on = 1'b0;
            next_st.send_on = 1'b0;
            next_st.mon_on = 1'b0;
            next_st.tx_busy = 1'b0;
            if (st.probe == ptpe_pkg::PTPE_PR_WAIT)
                next_st.probe = ptpe_pkg::PTPE_PR_IDLE;
            next_st.abort_busy = 1'b1;
        end else if (st.abort_busy && !any_active) begin
            next_st.abort_busy = 1'b0;
            next_st.abort_done = 1'b1;
        end
    end

    // --------------------------------------------------------------
    // state register
    // --------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // --------------------------------------------------------------
    // outputs
    // --------------------------------------------------------------
    // user data blocked on a standard circuit while a test owns the link
    assign user_ready = circuit_mux ? !st.tx_valid : !any_active;
    assign tx_valid = st.tx_valid;
    assign tx_sof = st.tx_sof;
    assign tx_eof = st.tx_eof;
    assign tx_test = st.tx_valid;
    assign tx_data = st.tx_data;
    assign loop_active = st.loop_on;
    assign send_active = st.send_on;
    assign mon_active = st.mon_on;
    assign probe_active = (st.probe == ptpe_pkg::PTPE_PR_WAIT);
    assign dte_loop_active = dte_loop_req;
    assign loop_elapsed_s = st.t_loop;
    assign send_elapsed_s = st.t_send;
    assign mon_elapsed_s = st.t_mon;
    assign in_sync = st.in_sync;
    assign seq_errors = st.seq_rep;
    assign data_errors = st.dat_rep;
    assign seq_overflow = st.seq_ovf;
    assign data_overflow = st.dat_ovf;
    assign rtt_ms = st.rtt;
    assign rtt_valid = st.rtt_ok;
    assign no_response = st.no_resp;
    assign abort_done = st.abort_done;
endmodule
`default_nettype wire

// file: ptpe_regs.svh
// constants for the per-circuit test pattern engine
`ifndef PTPE_REGS_SVH
`define PTPE_REGS_SVH
`define PTPE_FILL_BYTE 8'h55
`define PTPE_PAYLOAD_LEN 8'h10
`define PTPE_WIN_LEN 5'd25
`define PTPE_LOSS_LIMIT 5'd5
`define PTPE_CNT_MAX 17'd99999
`define PTPE_CLK_HZ 10000000
`define PTPE_MS_CYC 24'(`PTPE_CLK_HZ / 1000)
`define PTPE_SEC_LAST_MS 10'h3e7
`define PTPE_PROBE_LIMIT_S 5
`define PTPE_PROBE_LIMIT_MS 17'(`PTPE_PROBE_LIMIT_S * 1000)
`define PTPE_ZERO_CIR_BPS 24'd1000
`define PTPE_MUX_PCT 8'd10
`define PTPE_STD_PCT 8'd100
`define PTPE_PKT_BITS 24'((16 + 8 * 16) * 1)
`endif

// file: ptpe_pkg.sv
// types for the per-circuit test pattern engine
`default_nettype none
package ptpe_pkg;
    typedef enum logic [1:0] {PTPE_PR_IDLE, PTPE_PR_WAIT, PTPE_PR_DONE}
        ptpe_probe_e;
    typedef struct packed {
        logic loop_on;
        logic send_on;
        logic mon_on;
        ptpe_probe_e probe;
        logic [16:0] t_loop;
        logic [16:0] t_send;
        logic [16:0] t_mon;
        logic [16:0] t_probe;
        logic [23:0] ms_div;
        logic [9:0] sec_div;
        logic [31:0] rate_acc;
        logic [7:0] byte_idx;
        logic tx_busy;
        logic [7:0] tx_seq;
        logic [7:0] tx_data;
        logic tx_valid;
        logic tx_sof;
        logic tx_eof;
        logic [7:0] rx_seq_exp;
        logic rx_first;
        logic rx_bad_pkt;
        logic [7:0] rx_idx;
        logic [24:0] hist;
        logic in_sync;
        logic [16:0] seq_err;
        logic [16:0] dat_err;
        logic [16:0] seq_rep;
        logic [16:0] dat_rep;
        logic seq_ovf;
        logic dat_ovf;
        logic [16:0] rtt;
        logic rtt_ok;
        logic no_resp;
        logic abort_busy;
        logic abort_done;
    } ptpe_state_s;
endpackage
`default_nettype wire

// file: ptpe_engine_chk.sv
// port-level assertions for the test pattern engine
`timescale 1ns/1ns
`default_nettype none
`include "ptpe_regs.svh"
module ptpe_engine_chk (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic circuit_mux,
    input wire logic start_send,
    input wire logic stop_send,
    input wire logic start_probe,
    input wire logic abort_all,
    input wire logic dte_loop_req,
    input wire logic tx_valid,
    input wire logic tx_sof,
    input wire logic tx_eof,
    input wire logic tx_test,
    input wire logic [7:0] tx_data,
    input wire logic loop_active,
    input wire logic send_active,
    input wire logic mon_active,
    input wire logic probe_active,
    input wire logic dte_loop_active,
    input wire logic [16:0] rtt_ms,
    input wire logic rtt_valid,
    input wire logic no_response,
    input wire logic abort_done
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    // ----------------------------------------
    // control and pattern checks
    // ----------------------------------------
    a_send_starts: assert property (
        !send_active && start_send && !abort_all |=> send_active)
        else $error("send did not start");
    a_send_stops: assert property (
        send_active && stop_send && !start_send && !abort_all |=> !send_active)
        else $error("send did not stop");
    a_abort_done_at2: assert property (abort_all |-> ##2 abort_done)
        else $error("abort completion late");
    a_abort_all_idle: assert property (
        abort_done |-> !(loop_active || send_active || mon_active))
        else $error("test still active at abort completion");
    a_dte_loop_kept: assert property (
        dte_loop_req [*3] |-> dte_loop_active)
        else $error("terminal loopback dropped");
    a_fill_byte: assert property (
        tx_valid && tx_test && !tx_sof && !loop_active
        |-> tx_data == `PTPE_FILL_BYTE) else $error("bad fill byte");
    a_pkt_len: assert property (
        tx_valid && tx_sof && !tx_eof && !loop_active
        |-> ##16 (tx_valid && tx_eof)) else $error("bad packet length");
    a_probe_mux_only: assert property (
        start_probe && !circuit_mux && !probe_active |=> !probe_active)
        else $error("probe on standard circuit");
    a_rtt_result: assert property (
        rtt_valid |-> rtt_ms <= 17'h01388 && !no_response)
        else $error("bad round trip result");
    c_abort: cover property (abort_done);
    c_rtt: cover property ($rose(rtt_valid));
    c_pkt: cover property (tx_valid && tx_sof && send_active);
endmodule
bind ptpe_engine ptpe_engine_chk ptpe_engine_chk_i (.clk_sys(clk_sys),
    .reset_n(reset_n), .circuit_mux(circuit_mux), .start_send(start_send),
    .stop_send(stop_send), .start_probe(start_probe), .abort_all(abort_all),
    .dte_loop_req(dte_loop_req), .tx_valid(tx_valid), .tx_sof(tx_sof),
    .tx_eof(tx_eof), .tx_test(tx_test), .tx_data(tx_data),
    .loop_active(loop_active), .send_active(send_active),
    .mon_active(mon_active), .probe_active(probe_active),
    .dte_loop_active(dte_loop_active), .rtt_ms(rtt_ms),
    .rtt_valid(rtt_valid), .no_response(no_response),
    .abort_done(abort_done));
`default_nettype wire

// file: ptpe_peer.sv
// behavioural peer unit at the far end of the circuit
`timescale 1ns/1ns
`default_nettype none
module ptpe_peer (
    input wire logic clk_sys,
    input wire logic tx_valid,
    input wire logic tx_sof,
    input wire logic tx_eof,
    input wire logic tx_test,
    input wire logic [7:0] tx_data,
    input wire logic [31:0] reply_gap,
    output logic rx_valid,
    output logic rx_sof,
    output logic rx_eof,
    output logic rx_test,
    output logic rx_probe_reply,
    output logic [7:0] rx_data
);
    logic [11:0] q[$]; // reply, sof, eof, test, data
    int unsigned wait_cnt = 0;
    int unsigned fill_seen = 0;
    // queue one pattern frame: sequence byte, then 16 fill bytes
    task automatic send_frame(input logic [7:0] seq);
        q.push_back({4'h5, seq});
        for (int i = 0; i < 16; i++)
            q.push_back({2'b00, i == 15, 1'b1, 8'h55});
    endtask
    initial begin
        {rx_valid, rx_sof, rx_eof, rx_test, rx_probe_reply} = 5'h00;
        rx_data = 8'h00;
    end
    // one byte a cycle; idle data toggles so a stale byte never matches
    always @(negedge clk_sys) begin
        if (wait_cnt == 1)
            q.push_back({4'hf, 8'ha5}); // probe answer
        if (wait_cnt != 0)
            wait_cnt--;
        if (tx_valid && tx_sof && tx_eof)
            wait_cnt = reply_gap; // zero gap means a silent peer
        if (tx_valid && tx_test && !tx_sof && tx_data == 8'h55)
            fill_seen++;
        if (q.size() != 0) begin
            {rx_probe_reply, rx_sof, rx_eof, rx_test, rx_data} = q.pop_front();
            rx_valid = 1'b1;
        end else begin
            {rx_valid, rx_sof, rx_eof, rx_probe_reply} = 4'h0;
            rx_data = ~rx_data;
        end
    end
endmodule
`default_nettype wire

// file: testbench.sv
// self-checking bench for the test pattern engine
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin \
    n_errors++; $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp); \
    end end
module testbench;
    logic clk_sys, reset_n, circuit_mux, rate_override, dte_loop_req;
    logic [23:0] rate_bps, cir_bps;
    logic [4:0] st;
    logic [2:0] sp, act;
    logic [31:0] reply_gap;
    logic rx_valid, rx_sof, rx_eof, rx_test, rx_probe_reply, user_ready;
    logic [7:0] rx_data, tx_data, seq;
    logic tx_valid, tx_sof, tx_eof, tx_test, in_sync, rtt_valid;
    logic loop_active, send_active, mon_active, probe_active;
    logic dte_loop_active, no_response, abort_done;
    logic [16:0] rtt_ms;
    int n_errors = 0;
    int comparisons = 0;
    assign act = {mon_active, send_active, loop_active};
    ptpe_engine ptpe_engine_i (.clk_sys(clk_sys), .reset_n(reset_n),
        .circuit_mux(circuit_mux), .cir_bps(cir_bps),
        .rate_override(rate_override), .rate_bps(rate_bps),
        .timeout_en(1'b0), .timeout_s(17'h00000), .start_loop(st[0]),
        .stop_loop(sp[0]), .start_send(st[1]), .stop_send(sp[1]),
        .start_mon(st[2]), .stop_mon(sp[2]), .start_probe(st[3]),
        .abort_all(st[4]), .dte_loop_req(dte_loop_req), .rx_valid(rx_valid),
        .rx_sof(rx_sof), .rx_eof(rx_eof), .rx_test(rx_test),
        .rx_probe_reply(rx_probe_reply), .rx_data(rx_data),
        .user_valid(1'b0), .user_data(8'h00), .user_ready(user_ready),
        .tx_valid(tx_valid), .tx_sof(tx_sof), .tx_eof(tx_eof),
        .tx_test(tx_test), .tx_data(tx_data), .loop_active(loop_active),
        .send_active(send_active), .mon_active(mon_active),
        .probe_active(probe_active), .dte_loop_active(dte_loop_active),
        .loop_elapsed_s(), .send_elapsed_s(), .mon_elapsed_s(),
        .in_sync(in_sync), .seq_errors(), .data_errors(),
        .seq_overflow(), .data_overflow(), .rtt_ms(rtt_ms),
        .rtt_valid(rtt_valid), .no_response(no_response),
        .abort_done(abort_done));
    ptpe_peer ptpe_peer_i (.clk_sys(clk_sys), .tx_valid(tx_valid),
        .tx_sof(tx_sof), .tx_eof(tx_eof), .tx_test(tx_test),
        .tx_data(tx_data), .reply_gap(reply_gap), .rx_valid(rx_valid),
        .rx_sof(rx_sof), .rx_eof(rx_eof), .rx_test(rx_test),
        .rx_probe_reply(rx_probe_reply), .rx_data(rx_data));
    // ----------------------------------------
    // helpers; inputs only move on falling edges
    // ----------------------------------------
    task automatic tick(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    task automatic cmd(input logic [4:0] s, input logic [2:0] p);
        {st, sp} = {s, p};
        tick(1);
        {st, sp} = 8'h00;
        tick(1);
    endtask
    task automatic tally_and_finish;
        if (n_errors == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_start_stop; // second start while active is ignored
        for (int i = 0; i < 3; i++) begin
            repeat (2) cmd(5'h01 << i, 3'h0);
            `CHK(act, 3'h1 << i)
            cmd(5'h00, 3'h1 << i);
            `CHK(act, 3'h0)
        end
    endtask
    task automatic t_send; // two packets back to back, standard circuit
        int n;
        n = 0;
        cmd(5'h02, 3'h0);
        while (n < 30000 && tx_sof !== 1'b1) begin
            tick(1);
            n++;
        end
        `CHK(n < 12000, 1'b1)
        seq = tx_data;
        for (int k = 0; k < 16; k++) begin
            tick(1);
            `CHK(tx_data, 8'h55)
        end
        `CHK({tx_eof, user_ready}, 2'h2)
        tick(1);
        for (int i = 0; i < 30000 && tx_sof !== 1'b1; i++) tick(1);
        `CHK(tx_data, seq + 8'h01)
        cmd(5'h00, 3'h2);
        tick(20);
    endtask
    task automatic t_rate; // zero CIR floor, mux tenth, override wins
        int n;
        n = 0;
        cir_bps = 24'h000000;
        tick(1);
        `CHK(ptpe_engine_i.eff_rate, 24'h0003e8)
        cir_bps = 24'h075300;
        cmd(5'h02, 3'h0);
        `CHK(user_ready, 1'b1)
        while (n < 40000 && tx_sof !== 1'b1) begin
            tick(1);
            n++;
        end
        `CHK(n > 18000 && n < 40000, 1'b1)
        cmd(5'h00, 3'h2);
        tick(20);
        rate_override = 1'b1;
        n = 0;
        cmd(5'h02, 3'h0);
        while (n < 40000 && tx_sof !== 1'b1) begin
            tick(1);
            n++;
        end
        `CHK(n < 12000, 1'b1)
        cmd(5'h00, 3'h2);
        tick(20);
        rate_override = 1'b0;
    endtask
    task automatic t_loop; // frame from the peer comes straight back
        cmd(5'h01, 3'h0);
        ptpe_peer_i.fill_seen = 0;
        ptpe_peer_i.send_frame(8'h07);
        for (int i = 0; i < 200 && tx_sof !== 1'b1; i++) tick(1);
        `CHK({tx_test, tx_data}, 9'h107)
        tick(24);
        `CHK(ptpe_peer_i.fill_seen, 16)
        cmd(5'h00, 3'h1);
    endtask
    task automatic t_mon; // fourth bad frame keeps sync, fifth loses it
        cmd(5'h04, 3'h0);
        for (int i = 0; i < 30; i++) ptpe_peer_i.send_frame(8'(i));
        tick(560);
        `CHK(in_sync, 1'b1)
        for (int i = 0; i < 5; i++) begin
            ptpe_peer_i.send_frame(8'h80 + 8'(2 * i));
            tick(20);
            `CHK(in_sync, i < 4)
        end
        `CHK(ptpe_engine_i.st.seq_err, 17'h00005)
        `CHK(ptpe_engine_i.st.dat_err, 17'h00000)
        cmd(5'h00, 3'h4);
    endtask
    task automatic t_probe; // refused on standard, then one exchange
        cmd(5'h08, 3'h0);
        `CHK(probe_active, 1'b0)
        circuit_mux = 1'b1;
        reply_gap = 32'h00002710;
        cmd(5'h08, 3'h0);
        for (int i = 0; i < 30000 && rtt_valid !== 1'b1; i++) tick(1);
        `CHK(rtt_ms == 17'h00001 || rtt_ms == 17'h00002, 1'b1)
        tick(2);
        `CHK({probe_active, no_response}, 2'h0)
    endtask
    task automatic t_abort; // terminal loopback must survive
        dte_loop_req = 1'b1;
        cmd(5'h07, 3'h0);
        cmd(5'h10, 3'h0);
        for (int i = 0; i < 10 && abort_done !== 1'b1; i++) tick(1);
        `CHK(abort_done, 1'b1)
        `CHK({act, dte_loop_active}, 4'h1)
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    initial begin
        repeat (80000) @(posedge clk_sys);
        n_errors++;
        tally_and_finish();
    end
    initial begin
        {circuit_mux, rate_override, dte_loop_req, st, sp} = 11'h000;
        rate_bps = 24'h0f4240;
        cir_bps = 24'h075300;
        reply_gap = 32'h00000000;
        reset_n = 1'b0;
        tick(16);
        reset_n = 1'b1;
        tick(2);
        t_start_stop();
        t_send();
        t_loop();
        t_mon();
        t_probe();
        t_rate();
        t_abort();
        tally_and_finish();
    end
endmodule
`default_nettype wire
